/* File: logic/swrc_params.svh */
// Timing and command constants for the single-wire selection master.
`ifndef SWRC_PARAMS_SVH
`define SWRC_PARAMS_SVH
`define SWRC_CLK_MHZ        50
`define SWRC_RST_LOW_US     480
`define SWRC_RST_LOW_OD_US  48
`define SWRC_RST_WAIT_US    480
`define SWRC_RST_WAIT_OD_US 48
`define SWRC_PRES_SMP_US    70
`define SWRC_PRES_SMP_OD_US 9
`define SWRC_SLOT_US        65
`define SWRC_SLOT_OD_US     8
`define SWRC_LOW0_US        60
`define SWRC_LOW0_OD_US     7
`define SWRC_LOW1_US        6
`define SWRC_LOW1_OD_US     1
`define SWRC_SMP_US         12
`define SWRC_SMP_OD_US      2
`define SWRC_CYC(us)        ((us) * `SWRC_CLK_MHZ)
`define SWRC_CMD_READ       8'h33
`define SWRC_CMD_MATCH      8'h55
`define SWRC_CMD_SEARCH     8'hf0
`define SWRC_CMD_SKIP       8'hcc
`define SWRC_CMD_FSKIP      8'h3c
`endif

/* File: logic/swrc_pkg.sv */
// Types for the single-wire selection master.
`default_nettype none
package swrc_pkg;
  typedef enum logic [2:0] {
    SWRC_READ   = 3'h0,
    SWRC_MATCH  = 3'h1,
    SWRC_SEARCH = 3'h2,
    SWRC_SKIP   = 3'h3,
    SWRC_FSKIP  = 3'h4,
    SWRC_RAW    = 3'h5
  } swrc_op_e;
  typedef struct packed {
    swrc_op_e    op;
    logic [7:0]  code;
    logic [63:0] id;
  } swrc_req_s;
  typedef struct packed {
    logic        presence;
    logic        ok;
    logic [63:0] id;
  } swrc_rsp_s;
  typedef enum logic [3:0] {
    SWRC_IDLE    = 4'h0,
    SWRC_RLOW    = 4'h1,
    SWRC_RWAIT   = 4'h3,
    SWRC_CMD     = 4'h2,
    SWRC_BITS    = 4'h6,
    SWRC_SRCH    = 4'h7,
    SWRC_DONE    = 4'h5,
    SWRC_SLOT    = 4'h4,
    SWRC_SLOTEND = 4'hc
  } swrc_state_e;
endpackage
`default_nettype wire

/* File: logic/swrc_master.sv */
// Bus master that resets the single-wire line and issues selection commands.
`timescale 1ns/10ps
`default_nettype none
`include "swrc_params.svh"
module swrc_master
  import swrc_pkg::*;
(
  input  wire logic      clock_i,
  input  wire logic      reset_i,
  input  wire logic      start_i,
  input  wire logic      fast_reset_i,
  input  wire swrc_req_s req_i,
  input  wire logic      line_i,
  output logic           line_o,
  output logic           line_oe_o,
  output logic           busy_o,
  output logic           done_o,
  output swrc_rsp_s      rsp_o,
  output logic           fast_speed_flag_o
);

  swrc_state_e state_q;
  swrc_state_e ret_q;
  swrc_req_s   req_q;
  logic [1:0]  sync_q;
  logic [15:0] cnt_q;
  logic [6:0]  bit_q;
  logic [1:0]  step_q;
  logic        slot_wr_q;
  logic        slot_val_q;
  logic        slot_rd_q;
  logic        first_q;
  logic [7:0]  shift_q;
  logic [63:0] id_q;
  logic        fast_q;
  logic        oe_q;
  logic        busy_q;
  logic        done_q;
  logic        pres_q;
  logic        ok_q;
  logic        line_q;

  function automatic logic [15:0] cyc(input logic fast, input int reg_us, input int od_us);
    cyc = fast ? 16'(`SWRC_CYC(od_us)) : 16'(`SWRC_CYC(reg_us));
  endfunction

  // The line is a pin; two flops before anything reads it.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      sync_q <= 2'h3;
    else
      sync_q <= {sync_q[0], line_i};
  end

  // Every driver only releases or pulls low, so the driven level never leaves zero.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      line_q <= 1'b0;
    else
      line_q <= 1'b0;
  end

  // Busy and done follow the sequencer state, so both leave the block from flops.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == SWRC_DONE);
      if (state_q == SWRC_DONE)
        busy_q <= 1'b0;
      else if ((state_q == SWRC_IDLE) && start_i)
        busy_q <= 1'b1;
    end
  end

  // Transaction sequencer.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q    <= SWRC_IDLE;
      ret_q      <= SWRC_IDLE;
      req_q      <= '0;
      cnt_q      <= 16'h0;
      bit_q      <= 7'h0;
      step_q     <= 2'h0;
      slot_wr_q  <= 1'b0;
      slot_val_q <= 1'b1;
      slot_rd_q  <= 1'b1;
      first_q    <= 1'b0;
      shift_q    <= 8'h0;
      id_q       <= 64'h0;
      fast_q     <= 1'b0;
      oe_q       <= 1'b0;
      pres_q     <= 1'b0;
      ok_q       <= 1'b0;
    end
    else
    begin
      case (state_q)
        SWRC_IDLE:
        begin
          oe_q <= 1'b0;
          if (start_i)
          begin
            req_q   <= req_i;
            pres_q  <= 1'b0;
            ok_q    <= 1'b1;
            id_q    <= 64'h0;
            // A short reset keeps fast speed; a full one drops it.
            if (!(fast_reset_i && fast_q))
              fast_q <= 1'b0;
            cnt_q   <= (fast_reset_i && fast_q) ? cyc(1'b1, `SWRC_RST_LOW_US, `SWRC_RST_LOW_OD_US)
                                                : 16'(`SWRC_CYC(`SWRC_RST_LOW_US));
            oe_q    <= 1'b1;
            state_q <= SWRC_RLOW;
          end
        end
        SWRC_RLOW:
        begin
          if (cnt_q <= 16'h1)
          begin
            oe_q    <= 1'b0;
            cnt_q   <= cyc(fast_q, `SWRC_RST_WAIT_US, `SWRC_RST_WAIT_OD_US);
            state_q <= SWRC_RWAIT;
          end
          else
            cnt_q <= cnt_q - 16'h1;
        end
        SWRC_RWAIT:
        begin
          // Presence window sampled once, well inside the device's pull-down.
          if (cnt_q == cyc(fast_q, `SWRC_RST_WAIT_US, `SWRC_RST_WAIT_OD_US)
                       - cyc(fast_q, `SWRC_PRES_SMP_US, `SWRC_PRES_SMP_OD_US))
            pres_q <= ~sync_q[1];
          if (cnt_q <= 16'h1)
          begin
            bit_q   <= 7'h0;
            shift_q <= req_q.code;
            if (!pres_q)
            begin
              ok_q    <= 1'b0;
              state_q <= SWRC_DONE;
            end
            else
              state_q <= SWRC_CMD;
          end
          else
            cnt_q <= cnt_q - 16'h1;
        end
        SWRC_CMD:
        begin
          if (bit_q == 7'h8)
          begin
            bit_q  <= 7'h0;
            step_q <= 2'h0;
            case (req_q.op)
              SWRC_READ, SWRC_MATCH: state_q <= SWRC_BITS;
              SWRC_SEARCH:           state_q <= SWRC_SRCH;
              SWRC_FSKIP:
              begin
                fast_q  <= 1'b1;
                state_q <= SWRC_DONE;
              end
              default:               state_q <= SWRC_DONE;
            endcase
          end
          else
          begin
            slot_wr_q  <= 1'b1;
            slot_val_q <= shift_q[0];
            shift_q    <= {1'b0, shift_q[7:1]};
            bit_q      <= bit_q + 7'h1;
            ret_q      <= SWRC_CMD;
            state_q    <= SWRC_SLOT;
          end
        end
        SWRC_BITS:
        begin
          if (bit_q == 7'h40)
            state_q <= SWRC_DONE;
          else
          begin
            // Readout sends a release slot; match writes the target identity.
            slot_wr_q  <= (req_q.op == SWRC_MATCH);
            slot_val_q <= (req_q.op == SWRC_MATCH) ? req_q.id[bit_q[5:0]] : 1'b1;
            step_q     <= 2'h1;
            ret_q      <= SWRC_BITS;
            state_q    <= SWRC_SLOT;
          end
        end
        SWRC_SRCH:
        begin
          if (bit_q == 7'h40)
            state_q <= SWRC_DONE;
          else
          begin
            case (step_q)
              2'h0:
              begin
                slot_wr_q  <= 1'b0;
                slot_val_q <= 1'b1;
              end
              2'h1:
              begin
                first_q    <= slot_rd_q;
                slot_wr_q  <= 1'b0;
                slot_val_q <= 1'b1;
              end
              default:
              begin
                // Both bits zero means devices disagree; follow the requested path.
                if (first_q && slot_rd_q)
                  ok_q <= 1'b0;
                slot_wr_q  <= 1'b1;
                slot_val_q <= (first_q == slot_rd_q) ? req_q.id[bit_q[5:0]] : first_q;
                id_q[bit_q[5:0]] <= (first_q == slot_rd_q) ? req_q.id[bit_q[5:0]] : first_q;
              end
            endcase
            ret_q   <= SWRC_SRCH;
            state_q <= SWRC_SLOT;
          end
        end
        SWRC_SLOT:
        begin
          // Every slot opens with our own pull-down; we never drive high.
          oe_q    <= 1'b1;
          cnt_q   <= cyc(fast_q, `SWRC_SLOT_US, `SWRC_SLOT_OD_US);
          state_q <= SWRC_SLOTEND;
        end
        SWRC_SLOTEND:
        begin
          if (cnt_q == cyc(fast_q, `SWRC_SLOT_US, `SWRC_SLOT_OD_US)
                       - ((slot_wr_q && !slot_val_q) ? cyc(fast_q, `SWRC_LOW0_US, `SWRC_LOW0_OD_US)
                                                     : cyc(fast_q, `SWRC_LOW1_US, `SWRC_LOW1_OD_US)))
            oe_q <= 1'b0;
          if (cnt_q == cyc(fast_q, `SWRC_SLOT_US, `SWRC_SLOT_OD_US)
                       - cyc(fast_q, `SWRC_SMP_US, `SWRC_SMP_OD_US))
            slot_rd_q <= sync_q[1];
          if (cnt_q <= 16'h1)
          begin
            oe_q    <= 1'b0;
            state_q <= ret_q;
            if (ret_q == SWRC_BITS)
            begin
              if (req_q.op == SWRC_READ)
                id_q[bit_q[5:0]] <= slot_rd_q;
              else
                id_q[bit_q[5:0]] <= req_q.id[bit_q[5:0]];
              bit_q <= bit_q + 7'h1;
            end
            else if (ret_q == SWRC_SRCH)
            begin
              if (step_q == 2'h2)
              begin
                step_q <= 2'h0;
                bit_q  <= bit_q + 7'h1;
              end
              else
                step_q <= step_q + 2'h1;
            end
          end
          else
            cnt_q <= cnt_q - 16'h1;
        end
        SWRC_DONE:
        begin
          // The done pulse and the drop of busy come from their own process.
          state_q <= SWRC_IDLE;
        end
        default:
          state_q <= SWRC_IDLE;
      endcase
    end
  end

  assign line_o            = line_q;
  assign line_oe_o         = oe_q;
  assign busy_o            = busy_q;
  assign done_o            = done_q;
  assign rsp_o             = '{presence: pres_q, ok: ok_q, id: id_q};
  assign fast_speed_flag_o = fast_q;

endmodule
`default_nettype wire

/* File: bench/swrc_master_sva.sv */
// Assertions on the ports of the selection master.
`timescale 1ns/10ps
`default_nettype none
module swrc_master_sva
  import swrc_pkg::*;
(
  input wire logic      clock_i,
  input wire logic      reset_i,
  input wire logic      start_i,
  input wire logic      fast_reset_i,
  input wire swrc_req_s req_i,
  input wire logic      line_i,
  input wire logic      line_o,
  input wire logic      line_oe_o,
  input wire logic      busy_o,
  input wire logic      done_o,
  input wire swrc_rsp_s rsp_o,
  input wire logic      fast_speed_flag_o
);
  logic [15:0] low_q;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  // Counting the low time lets every pulse be judged against the fixed slot and reset lengths.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      low_q <= 16'h0;
    else
      low_q <= line_oe_o ? low_q + 16'h1 : 16'h0;
  end
  drain_only_a: assert property (line_o == 1'b0) else $error("line driven high");
  start_pull_a: assert property (start_i && !busy_o |=> busy_o && line_oe_o) else $error("start not taken");
  done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o) else $error("done not a pulse");
  idle_free_a: assert property (!busy_o |-> !line_oe_o) else $error("line held while idle");
  low_len_a: assert property ($fell(line_oe_o) |-> low_q inside {[16'h12b:16'h12d], [16'hbb7:16'hbb9],
    [16'h31:16'h33], [16'h15d:16'h15f], [16'h95f:16'h961], [16'h5dbf:16'h5dc1]}) else $error("bad low time");
  flag_set_a: assert property ($rose(fast_speed_flag_o) |-> busy_o ##1 (done_o && rsp_o.ok))
    else $error("flag set outside a finished selection");
  flag_clear_a: assert property ($fell(fast_speed_flag_o) |-> busy_o && !fast_reset_i) else $error("flag lost");
  rsp_hold_a: assert property (!busy_o && !start_i |=> $stable(rsp_o)) else $error("result moved");
  absent_fail_a: assert property (done_o && !rsp_o.presence |-> !rsp_o.ok) else $error("ok without presence");
  cover property (done_o && rsp_o.ok);
  cover property ($rose(fast_speed_flag_o));
  cover property ($fell(line_oe_o) && low_q > 16'h5000);
endmodule
bind swrc_master swrc_master_sva chk_u (.clock_i, .reset_i, .start_i, .fast_reset_i, .req_i, .line_i,
  .line_o, .line_oe_o, .busy_o, .done_o, .rsp_o, .fast_speed_flag_o);
`default_nettype wire

/* File: bench/swrc_dev.sv */
// Behavioural model of the single-wire device that answers the master.
`timescale 1ns/10ps
`default_nettype none
module swrc_dev
#(
  parameter logic [63:0] DEV_ID = 64'h0123_4567_89ab_cdef // Arbitrary value.
)
(
  input  wire logic line_i,
  output logic      pull_o,
  output logic      fast_o
);
  int         ph = 4;
  int         n = 0;
  int         st = 0;
  logic       b;
  logic [7:0] cmd;
  realtime    t0;
  initial
  begin
    pull_o = 1'b0;
    fast_o = 1'b0;
    forever
    begin
      @(negedge line_i);
      t0 = $realtime;
      if (ph == 1 || (ph == 3 && st < 2))
      begin
        pull_o = ~(DEV_ID[n] ^ (st == 1));
        #(fast_o ? 3000 : 15000);
        pull_o = 1'b0;
      end
      else
        #(fast_o ? 3500 : 30000);
      b = line_i;
      wait (line_i === 1'b1);
      // A slow slot can never reach the reset threshold, so length alone tells them apart.
      if ($realtime - t0 >= (fast_o ? 40000 : 400000))
      begin
        if ($realtime - t0 >= 480000)
          fast_o = 1'b0;
        #(fast_o ? 3000 : 30000);
        pull_o = 1'b1;
        #(fast_o ? 12000 : 120000);
        pull_o = 1'b0;
        ph = 0;
        n = 0;
        st = 0;
      end
      else if (ph == 0)
      begin
        cmd[n] = b;
        n++;
        if (n == 8)
        begin
          n = 0;
          ph = (cmd == 8'h33) ? 1 : (cmd == 8'h55) ? 2 : (cmd == 8'hf0) ? 3 : 4;
          if (cmd == 8'h3c)
            fast_o = 1'b1;
        end
      end
      else if (ph == 2 && b !== DEV_ID[n])
        ph = 4;
      else if (ph == 3 && st == 2 && b !== DEV_ID[n])
        ph = 4;
      else if (ph == 3 && st < 2)
        st++;
      else if (ph != 4)
      begin
        st = 0;
        n++;
        if (n == 64)
          ph = 4;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the selection master against a device model.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import swrc_pkg::*;
;
  localparam logic [63:0] ID = 64'h5a3c_0f96_1e2d_4b87; // Arbitrary value.
  logic      clock_i = 1'b0;
  logic      reset_i = 1'b1;
  logic      start_i = 1'b0;
  logic      fast_reset_i = 1'b0;
  swrc_req_s req_i = '0;
  logic      line_o;
  logic      line_oe;
  logic      busy;
  logic      done;
  logic      flag;
  swrc_rsp_s rsp;
  logic      dev_pull;
  logic      dev_fast;
  wire logic line_w;
  int        num_errors = 0;
  int        n_compared = 0;
  assign line_w = !((line_oe && !line_o) || dev_pull);
  always #10 clock_i = ~clock_i;
  swrc_master dut_u (.clock_i(clock_i), .reset_i(reset_i), .start_i(start_i), .fast_reset_i(fast_reset_i),
    .req_i(req_i), .line_i(line_w), .line_o(line_o), .line_oe_o(line_oe), .busy_o(busy), .done_o(done),
    .rsp_o(rsp), .fast_speed_flag_o(flag));
  swrc_dev #(.DEV_ID(ID)) dev_u (.line_i(line_w), .pull_o(dev_pull), .fast_o(dev_fast));
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic run(input swrc_op_e op, input logic [7:0] code, input logic fr);
    int k;
    @(negedge clock_i);
    req_i.op = op;
    req_i.code = code;
    req_i.id = ID;
    fast_reset_i = fr;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    for (k = 0; k < 200000 && done !== 1'b1; k++)
      @(negedge clock_i);
    if (k == 200000)
    begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic test_fast_skip();
    run(SWRC_FSKIP, 8'h3c, 1'b0);
    check("presence", 64'h1, 64'(rsp.presence));
    check("fast flag", 64'h1, 64'(flag));
    check("device speed", 64'h1, 64'(dev_fast));
    $display("fast skip test ended");
  endtask
  task automatic test_fast_read();
    run(SWRC_READ, 8'h33, 1'b1);
    check("identity", ID, rsp.id);
    check("ok", 64'h1, 64'(rsp.ok));
    check("flag kept", 64'h1, 64'(flag));
    $display("fast read test ended");
  endtask
  // A full-length reset drops fast speed at once; a second start while busy is refused,
  // and a mid-run reset must leave the line released and the block idle.
  task automatic test_abort();
    @(negedge clock_i);
    req_i.op = SWRC_SKIP;
    req_i.code = 8'hcc;
    fast_reset_i = 1'b0;
    start_i = 1'b1;
    @(negedge clock_i);
    check("flag cleared", 64'h0, 64'(flag));
    check("reset pull", 64'h1, 64'(line_oe));
    @(negedge clock_i);
    start_i = 1'b0;
    @(negedge clock_i);
    check("busy kept", 64'h1, 64'(busy));
    check("pull kept", 64'h1, 64'(line_oe));
    reset_i = 1'b1;
    repeat (2) @(negedge clock_i);
    reset_i = 1'b0;
    @(negedge clock_i);
    check("line released", 64'h0, 64'(line_oe));
    check("idle after reset", 64'h0, 64'(busy));
    check("no done after reset", 64'h0, 64'(done));
    $display("abort test ended");
  endtask
  initial
  begin
    repeat (12) @(negedge clock_i);
    reset_i = 1'b0;
    test_fast_skip();
    test_fast_read();
    test_abort();
    close_out();
  end
endmodule
`default_nettype wire
